// ===== design/sfof_framer.sv
// output stream framer with status channel modes and host registers
`include "sfof_cfg.svh"
`default_nettype none

module sfof_framer (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // transfer request
    input wire logic req_valid_in,
    input wire logic [1:0] req_chan_in,
    input wire logic req_resp_in,
    input wire logic [6:0] req_nfull_in,
    input wire logic [7:0] req_last_len_in,
    output logic req_ready_out,
    // packed sensor data
    input wire logic [7:0] in_data_in,
    input wire logic in_valid_in,
    input wire logic in_last_in,
    output logic in_ready_out,
    // time base and loss report
    input wire logic [39:0] stamp_in,
    input wire logic block_lost_in,
    // output stream
    output logic [7:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    // host registers
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // host interrupt pin
    output logic irq_out
);

    sfof_pkg::sfof_state_t st_ff;
    sfof_pkg::sfof_state_t nxt_st;
    logic [7:0] link_ctrl_ff;
    logic [7:0] mask_ctrl_ff;
    logic sync_avail_ff;
    logic async_avail_ff;
    logic raw_ff;
    logic no_ts_ff;
    logic [15:0] len_ff;
    logic [6:0] blocks_left_ff;
    logic [1:0] desc_idx_ff;
    logic [3:0] hdr_idx_ff;
    logic [9:0] blk_cnt_ff;
    logic [15:0] blk_ctr_ff;
    logic lost_ff;
    logic [7:0] meta_type_ff;
    logic [39:0] stamp_ff;
    logic [7:0] hold_ff;
    logic hold_v_ff;
    logic data_done_ff;
    logic nxt_hold_v;
    logic nxt_data_done;

    wire logic [15:0] calc_len;
    wire logic [7:0] hdr_byte;
    wire logic [3:0] hdr_len;
    wire logic async_mode;
    wire logic is_status;
    wire logic req_raw;
    wire logic req_ok;
    wire logic req_take;
    wire logic adv;
    wire logic acc;
    wire logic final_blk;
    wire logic fill_met;
    wire logic emit_desc;
    wire logic emit_hdr;
    wire logic emit_data;
    wire logic emit_fill;
    wire logic emit;
    wire logic hdr_end;
    wire logic start_blk;
    wire logic done_now;
    wire logic [7:0] desc_byte;
    wire logic [7:0] emit_byte;
    wire logic wr_link;
    wire logic wr_mask;
    wire logic rd_cause;
    wire logic [7:0] cause_val;
    wire logic [7:0] rd_val;
    wire logic irq_nxt;

    // length of a framed transfer
    sfof_len_calc u_len (
        .nfull_in(req_nfull_in),
        .last_len_in(req_last_len_in),
        .no_ts_in(link_ctrl_ff[`SFOF_BIT_NO_TS]),
        .total_out(calc_len)
    );

    // header byte selection
    sfof_hdr_mux u_hdr (
        .idx_in(hdr_idx_ff),
        .meta_type_in(meta_type_ff),
        .count_in(blk_ctr_ff),
        .stamp_in(stamp_ff),
        .byte_out(hdr_byte)
    );

    // channel mode and request acceptance
    assign async_mode = link_ctrl_ff[`SFOF_BIT_ASYNC];
    assign is_status = (req_chan_in == `SFOF_STATUS_CHAN);
    assign req_raw = is_status & ~async_mode & req_resp_in;
    assign req_ok = ~(is_status & ~async_mode & ~req_resp_in);
    assign req_take = ce_in & req_valid_in & req_ready_out & req_ok;

    // stream handshakes and block bookkeeping
    assign adv = ~out_valid_out | out_ready_in;
    assign acc = ce_in & in_valid_in & in_ready_out;
    assign hdr_len = sfof_pkg::sfof_hdr_len(no_ts_ff);
    assign final_blk = (blocks_left_ff == 7'h00);
    assign fill_met = sfof_pkg::sfof_pad_done(blk_cnt_ff, final_blk);
    assign done_now = data_done_ff | (acc & in_last_in);

    // which state puts a byte out this cycle
    assign emit_desc = (st_ff == sfof_pkg::SFOF_DESC) & adv;
    assign emit_hdr = (st_ff == sfof_pkg::SFOF_HDR) & adv;
    assign emit_data = (st_ff == sfof_pkg::SFOF_DATA) & adv
                       & (hold_v_ff | acc);
    assign emit_fill = (st_ff == sfof_pkg::SFOF_FILL) & adv & ~fill_met;
    assign emit = ce_in & (emit_desc | emit_hdr | emit_data | emit_fill);
    assign hdr_end = ce_in & emit_hdr & (hdr_idx_ff == hdr_len - 4'h1);
    assign start_blk = ce_in & (nxt_st == sfof_pkg::SFOF_HDR)
                       & (st_ff != sfof_pkg::SFOF_HDR);

    // descriptor: length low then high, then the zero delta stamp
    assign desc_byte = (desc_idx_ff == 2'h0) ? len_ff[7:0] :
                       (desc_idx_ff == 2'h1) ? len_ff[15:8] :
                       8'h00;

    // byte sent this cycle
    assign emit_byte =
        (st_ff == sfof_pkg::SFOF_DESC) ? desc_byte :
        (st_ff == sfof_pkg::SFOF_HDR) ? hdr_byte :
        (st_ff == sfof_pkg::SFOF_DATA) ? (hold_v_ff ? hold_ff : in_data_in) :
        (final_blk ? `SFOF_PAD : `SFOF_FILLER);

    // transfer sequencer
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            sfof_pkg::SFOF_IDLE: begin
                if (req_take) begin
                    nxt_st = req_raw ? sfof_pkg::SFOF_DATA
                                     : sfof_pkg::SFOF_DESC;
                end
            end
            sfof_pkg::SFOF_DESC: begin
                if (emit && desc_idx_ff == `SFOF_DESC_LAST) begin
                    nxt_st = sfof_pkg::SFOF_HDR;
                end
            end
            sfof_pkg::SFOF_HDR: begin
                if (hdr_end) begin
                    nxt_st = sfof_pkg::SFOF_DATA;
                end
            end
            sfof_pkg::SFOF_DATA: begin
                if (ce_in && done_now && !nxt_hold_v) begin
                    nxt_st = raw_ff ? sfof_pkg::SFOF_IDLE
                                    : sfof_pkg::SFOF_FILL;
                end
            end
            sfof_pkg::SFOF_FILL: begin
                if (ce_in && fill_met) begin
                    nxt_st = final_blk ? sfof_pkg::SFOF_IDLE
                                       : sfof_pkg::SFOF_HDR;
                end
            end
        endcase
    end

    // one-byte holding slot keeps input ready a plain flop
    always_comb begin
        nxt_hold_v = hold_v_ff;
        if (ce_in && st_ff == sfof_pkg::SFOF_DATA) begin
            if (adv) begin
                nxt_hold_v = hold_v_ff & acc;
            end else if (acc) begin
                nxt_hold_v = 1'b1;
            end
        end
        nxt_data_done = (nxt_st == sfof_pkg::SFOF_DATA) & done_now;
    end

    // sequencer and handshake flops
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= sfof_pkg::SFOF_IDLE;
            hold_v_ff <= 1'b0;
            data_done_ff <= 1'b0;
            in_ready_out <= 1'b0;
            req_ready_out <= 1'b0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
            hold_v_ff <= nxt_hold_v;
            data_done_ff <= nxt_data_done;
            in_ready_out <= (nxt_st == sfof_pkg::SFOF_DATA) & ~nxt_hold_v
                            & ~nxt_data_done;
            req_ready_out <= (nxt_st == sfof_pkg::SFOF_IDLE);
        end
    end

    // data held back while the output stage is busy
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_ff <= 8'h00;
        end else if (acc && !(adv && !hold_v_ff)) begin
            hold_ff <= in_data_in;
        end
    end

    // output stage
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_data_out <= 8'h00;
            out_valid_out <= 1'b0;
        end else if (ce_in && adv) begin
            out_valid_out <= emit;
            if (emit) begin
                out_data_out <= emit_byte;
            end
        end
    end

    // transfer parameters caught when a request is taken
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            raw_ff <= 1'b0;
            no_ts_ff <= 1'b0;
            len_ff <= 16'h0000;
            blocks_left_ff <= 7'h00;
        end else if (req_take) begin
            raw_ff <= req_raw;
            no_ts_ff <= link_ctrl_ff[`SFOF_BIT_NO_TS];
            len_ff <= calc_len;
            blocks_left_ff <= req_nfull_in;
        end else if (start_blk && st_ff == sfof_pkg::SFOF_FILL) begin
            blocks_left_ff <= blocks_left_ff - 7'h01;
        end
    end

    // position counters within descriptor, header and block
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            desc_idx_ff <= 2'h0;
            hdr_idx_ff <= 4'h0;
            blk_cnt_ff <= 10'h000;
        end else if (ce_in) begin
            if (req_take) begin
                desc_idx_ff <= 2'h0;
            end else if (emit_desc) begin
                desc_idx_ff <= desc_idx_ff + 2'h1;
            end
            if (start_blk) begin
                hdr_idx_ff <= 4'h0;
                blk_cnt_ff <= 10'h000;
            end else begin
                if (emit_hdr) begin
                    hdr_idx_ff <= hdr_idx_ff + 4'h1;
                end
                if (emit && !emit_desc) begin
                    blk_cnt_ff <= blk_cnt_ff + 10'h001;
                end
            end
        end
    end

    // header contents: loss memory, meta type, stamp, block count
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lost_ff <= 1'b0;
            meta_type_ff <= `SFOF_META_SPACER;
            stamp_ff <= 40'h00_0000_0000;
            blk_ctr_ff <= 16'h0000;
        end else if (ce_in) begin
            lost_ff <= block_lost_in | (lost_ff & ~start_blk);
            if (start_blk) begin
                meta_type_ff <= (lost_ff | block_lost_in)
                                ? `SFOF_META_OVERFLOW
                                : `SFOF_META_SPACER;
                stamp_ff <= stamp_in;
            end
            if (hdr_end) begin
                blk_ctr_ff <= blk_ctr_ff + 16'h0001;
            end
        end
    end

    // host register decode
    assign wr_link = reg_wr_in & (reg_addr_in == `SFOF_ADDR_LINK);
    assign wr_mask = reg_wr_in & (reg_addr_in == `SFOF_ADDR_MASK);
    assign rd_cause = reg_rd_in & (reg_addr_in == `SFOF_ADDR_CAUSE);
    assign cause_val = {1'b0, async_avail_ff, sync_avail_ff, 5'h00};
    assign rd_val = (reg_addr_in == `SFOF_ADDR_LINK) ? link_ctrl_ff :
                    (reg_addr_in == `SFOF_ADDR_MASK) ? mask_ctrl_ff :
                    (reg_addr_in == `SFOF_ADDR_CAUSE) ? cause_val :
                    8'h00;

    // control registers and read data
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_ctrl_ff <= `SFOF_LINK_RST;
            mask_ctrl_ff <= `SFOF_MASK_RST;
            reg_rdata_out <= 8'h00;
        end else if (ce_in) begin
            if (wr_link) begin
                link_ctrl_ff <= reg_wdata_in;
            end
            if (wr_mask) begin
                mask_ctrl_ff <= reg_wdata_in;
            end
            if (reg_rd_in) begin
                reg_rdata_out <= rd_val;
            end
        end
    end

    // cause flags clear on read; a new event in that cycle wins
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_avail_ff <= 1'b0;
            async_avail_ff <= 1'b0;
        end else if (ce_in) begin
            sync_avail_ff <= (req_take & req_raw)
                             | (sync_avail_ff & ~rd_cause);
            async_avail_ff <= (req_take & is_status & ~req_raw)
                              | (async_avail_ff & ~rd_cause);
        end
    end

    // interrupt pin with per-cause masks
    assign irq_nxt = (sync_avail_ff & ~mask_ctrl_ff[`SFOF_BIT_MASK_SYNC])
                     | (async_avail_ff
                        & ~mask_ctrl_ff[`SFOF_BIT_MASK_ASYNC]);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_out <= irq_nxt;
        end
    end

endmodule : sfof_framer

`default_nettype wire

// ===== design/sfof_hdr_mux.sv
// selects one byte of a block header
`include "sfof_cfg.svh"
`default_nettype none

module sfof_hdr_mux (
    // header position and contents
    input wire logic [3:0] idx_in,
    input wire logic [7:0] meta_type_in,
    input wire logic [15:0] count_in,
    input wire logic [39:0] stamp_in,
    // selected byte
    output logic [7:0] byte_out
);

    // meta event, then the stamp, low byte first everywhere
    always_comb begin
        unique case (idx_in)
            4'h0: byte_out = `SFOF_META_ID;
            4'h1: byte_out = meta_type_in;
            4'h2: byte_out = count_in[7:0];
            4'h3: byte_out = count_in[15:8];
            4'h4: byte_out = stamp_in[7:0];
            4'h5: byte_out = stamp_in[15:8];
            4'h6: byte_out = stamp_in[23:16];
            4'h7: byte_out = stamp_in[31:24];
            4'h8: byte_out = stamp_in[39:32];
            default: byte_out = `SFOF_PAD;
        endcase
    end

endmodule : sfof_hdr_mux

`default_nettype wire

// ===== design/sfof_len_calc.sv
// transfer length for the descriptor of a framed transfer
`include "sfof_cfg.svh"
`default_nettype none

module sfof_len_calc (
    // request shape
    input wire logic [6:0] nfull_in,
    input wire logic [7:0] last_len_in,
    input wire logic no_ts_in,
    // byte count after the length field
    output logic [15:0] total_out
);

    wire logic [9:0] last_raw;
    wire logic [9:0] last_blk;

    // final block: header plus data, rounded up to a whole word
    assign last_raw = {6'h00, sfof_pkg::sfof_hdr_len(no_ts_in)}
                      + {2'h0, last_len_in};
    assign last_blk = (last_raw + 10'h003) & 10'h3FC;
    // delta stamp, full blocks, final block
    assign total_out = `SFOF_DELTA_TS + {nfull_in, 9'h000}
                       + {6'h00, last_blk};

endmodule : sfof_len_calc

`default_nettype wire

// ===== include/sfof_cfg.svh
// offsets, field positions, reset values and byte codes of the output framer
`ifndef SFOF_CFG_SVH
`define SFOF_CFG_SVH

// host register offsets
`define SFOF_ADDR_LINK 8'h06
`define SFOF_ADDR_MASK 8'h07
`define SFOF_ADDR_CAUSE 8'h2D

// reset values
`define SFOF_LINK_RST 8'h00
`define SFOF_MASK_RST 8'h00

// field positions in host_link_control
`define SFOF_BIT_ASYNC 0
`define SFOF_BIT_NO_TS 1

// field positions in host_irq_mask_control
`define SFOF_BIT_MASK_SYNC 2
`define SFOF_BIT_MASK_ASYNC 3

// field positions in irq_cause_flags
`define SFOF_BIT_SYNC_AVAIL 5
`define SFOF_BIT_ASYNC_AVAIL 6

// block geometry
`define SFOF_BLOCK_BYTES 10'h200
`define SFOF_HDR_FULL 4'h9
`define SFOF_HDR_SHORT 4'h4
`define SFOF_DESC_LAST 2'h3
`define SFOF_DELTA_TS 16'h0002
`define SFOF_STATUS_CHAN 2'h3

// byte codes
`define SFOF_FILLER 8'hFF
`define SFOF_PAD 8'h00
`define SFOF_META_ID 8'hFE
`define SFOF_META_SPACER 8'h01
`define SFOF_META_OVERFLOW 8'h02

`endif

// ===== include/sfof_pkg.sv
// types and shared helpers of the output framer
`include "sfof_cfg.svh"
`default_nettype none

package sfof_pkg;

    typedef enum logic [2:0] {
        SFOF_IDLE,
        SFOF_DESC,
        SFOF_HDR,
        SFOF_DATA,
        SFOF_FILL
    } sfof_state_t;

    // header length in bytes, with or without the full timestamp
    function automatic logic [3:0] sfof_hdr_len(input logic no_ts);
        sfof_hdr_len = no_ts ? `SFOF_HDR_SHORT : `SFOF_HDR_FULL;
    endfunction : sfof_hdr_len

    // true once a block has reached its filler or padding target
    function automatic logic sfof_pad_done(input logic [9:0] cnt,
                                           input logic final_blk);
        sfof_pad_done = final_blk ? (cnt[1:0] == 2'h0)
                                  : (cnt == `SFOF_BLOCK_BYTES);
    endfunction : sfof_pad_done

endpackage : sfof_pkg

`default_nettype wire

// ===== verification/sfof_framer_asserts.sv
// concurrent checks on the output framer ports
`default_nettype none

module sfof_framer_asserts (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // request and output stream
    input wire logic req_valid_in,
    input wire logic [1:0] req_chan_in,
    input wire logic req_resp_in,
    input wire logic req_ready_out,
    input wire logic [7:0] out_data_out,
    input wire logic out_valid_out,
    input wire logic out_ready_in,
    // host registers and pin
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic irq_out
);
    logic [7:0] link_ff;
    logic [7:0] mask_ff;
    logic wr_ok;

    // shadow copies of the two writable registers
    assign wr_ok = reg_wr_in && ce_in;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_ff <= 8'h00;
            mask_ff <= 8'h00;
        end else begin
            if (wr_ok && reg_addr_in == 8'h06)
                link_ff <= reg_wdata_in;
            if (wr_ok && reg_addr_in == 8'h07)
                mask_ff <= reg_wdata_in;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // write then read of one address on consecutive cycles
    sequence s_wr_rd(a);
        wr_ok && reg_addr_in == a ##1 reg_rd_in && ce_in && reg_addr_in == a;
    endsequence
    // a request the framer may take now
    sequence s_take;
        req_valid_in && req_ready_out && ce_in
            && !(req_chan_in == 2'h3 && !link_ff[0] && !req_resp_in);
    endsequence

    property p_link_rw;
        s_wr_rd(8'h06) |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_link_rw: assert property (p_link_rw)
        else $error("link readback wrong");
    property p_mask_rw;
        s_wr_rd(8'h07) |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_mask_rw: assert property (p_mask_rw)
        else $error("mask readback wrong");
    property p_unmapped;
        reg_rd_in && ce_in && !(reg_addr_in inside {8'h06, 8'h07, 8'h2D})
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_cause_bits;
        reg_rd_in && ce_in && reg_addr_in == 8'h2D
            |=> (reg_rdata_out & 8'h9F) == 8'h00;
    endproperty
    a_cause_bits: assert property (p_cause_bits)
        else $error("cause unused bits set");
    property p_rdata_hold;
        $past(!(reg_rd_in && ce_in)) |-> $stable(reg_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved");
    property p_out_hold;
        out_valid_out && !out_ready_in && ce_in
            |=> out_valid_out && $stable(out_data_out);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("stalled byte changed");
    property p_irq_masked;
        mask_ff[3:2] == 2'h3 && $past(mask_ff[3:2]) == 2'h3 |-> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("irq while masked");
    property p_req_taken;
        s_take |=> !req_ready_out ##1 out_valid_out;
    endproperty
    a_req_taken: assert property (p_req_taken)
        else $error("request did not start");
    property p_req_wait;
        req_valid_in && req_ready_out && ce_in && req_chan_in == 2'h3
            && !link_ff[0] && !req_resp_in |=> req_ready_out;
    endproperty
    a_req_wait: assert property (p_req_wait)
        else $error("status data taken in sync mode");
endmodule : sfof_framer_asserts

bind sfof_framer sfof_framer_asserts u_asserts (.*);

`default_nettype wire

// ===== verification/sfof_framer_test.sv
// self-checking bench for the output framer
`default_nettype none

module sfof_framer_test;
    timeunit 1ns;
    timeprecision 1ps;

    // design ports
    logic sys_clk_in = 1'b0;
    logic rst_n_in, ce_in, req_valid_in, req_resp_in, req_ready_out;
    logic [1:0] req_chan_in;
    logic [6:0] req_nfull_in;
    logic [7:0] req_last_len_in, in_data_in, out_data_out;
    logic in_valid_in, in_last_in, in_ready_out, block_lost_in;
    logic [39:0] stamp_in;
    logic out_valid_out, out_ready_in, slow_in, reg_wr_in, reg_rd_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic irq_out;
    // expected stream and source bytes {last, data}
    logic [7:0] exp_q[$];
    logic [8:0] src_q[$];
    int err_total = 0;
    int check_count = 0;

    sfof_framer dut (.*);
    sfof_host_model host (.sys_clk_in, .data_in(out_data_out),
        .valid_in(out_valid_out), .slow_in, .ready_out(out_ready_in));

    // 125 MHz clock
    always #4 sys_clk_in = ~sys_clk_in;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
        @(negedge sys_clk_in);
        reg_wr_in = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge sys_clk_in);
        reg_rd_in = 1'b0;
        @(negedge sys_clk_in);
        d = reg_rdata_out;
    endtask : reg_rd

    task automatic put16(input logic [15:0] v);
        exp_q.push_back(v[7:0]);
        exp_q.push_back(v[15:8]);
    endtask : put16

    task automatic start(input logic framed);
        exp_q.delete();
        src_q.delete();
        repeat (framed ? 2 : 0) put16(16'h0000); // length, zero stamp
    endtask : start

    task automatic put_hdr(input logic [7:0] kind, input logic [15:0] cnt,
                           input logic ts);
        exp_q.push_back(8'hFE);
        exp_q.push_back(kind);
        put16(cnt);
        for (int i = 0; i < 5 && ts; i++)
            exp_q.push_back(stamp_in[8*i +: 8]);
    endtask : put_hdr

    task automatic put_data(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(base + 8'(i));
            src_q.push_back({i == n - 1, base + 8'(i)});
        end
    endtask : put_data

    task automatic pad_to(input int s, input int al, input logic [7:0] v);
        while ((exp_q.size() - s) % al != 0)
            exp_q.push_back(v);
    endtask : pad_to

    task automatic frame_len();
        logic [15:0] n;
        n = 16'(exp_q.size() - 2);
        exp_q[0] = n[7:0];
        exp_q[1] = n[15:8];
    endtask : frame_len

    // source bytes, each held until the framer takes it
    task automatic feed();
        while (src_q.size() > 0) begin
            @(negedge sys_clk_in);
            {in_last_in, in_data_in} = src_q[0];
            in_valid_in = 1'b1;
            if (in_ready_out === 1'b1)
                void'(src_q.pop_front());
        end
        @(negedge sys_clk_in);
        in_valid_in = 1'b0;
    endtask : feed

    task automatic run(input logic [1:0] ch, input logic rs,
                       input logic [6:0] nf, input logic [7:0] ll,
                       input logic slow);
        int n;
        host.got_q.delete();
        slow_in = slow;
        fork
            begin
                @(negedge sys_clk_in);
                {req_chan_in, req_resp_in, req_nfull_in} = {ch, rs, nf};
                req_last_len_in = ll;
                req_valid_in = 1'b1;
                for (n = 0; n < 200 && req_ready_out !== 1'b0; n++)
                    @(negedge sys_clk_in);
                req_valid_in = 1'b0;
            end
            feed();
        join
        for (n = 0; n < 3000 && host.got_q.size() < exp_q.size(); n++)
            @(negedge sys_clk_in);
        repeat (4) @(negedge sys_clk_in);
        check(16'(host.got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i])
            if (i < host.got_q.size())
                check(host.got_q[i], exp_q[i]);
    endtask : run

    task automatic t_regs();
        logic [7:0] v;
        reg_rd(8'h06, v);
        check(v, 8'h00);
        reg_rd(8'h07, v);
        check(v, 8'h00);
        reg_rd(8'h10, v);
        check(v, 8'h00);
        reg_wr(8'h2D, 8'h60);
        reg_rd(8'h2D, v);
        check(v, 8'h00);
        reg_wr(8'h07, 8'h0C);
        reg_rd(8'h07, v);
        check(v, 8'h0C);
        repeat (3) @(negedge sys_clk_in);
        reg_wr(8'h07, 8'h00);
        reg_wr(8'h06, 8'h02); // stamps off, no loss ahead
        reg_rd(8'h06, v);
        check(v, 8'h02);
        $display("regs done");
    endtask : t_regs

    task automatic t_single();
        start(1'b1);
        put_hdr(8'h01, 16'h0000, 1'b0);
        put_data(5, 8'h40);
        pad_to(4, 4, 8'h00);
        frame_len();
        run(2'h0, 1'b0, 7'h00, 8'h05, 1'b0);
        $display("single done");
    endtask : t_single

    task automatic t_multi();
        reg_wr(8'h06, 8'h00);
        block_lost_in = 1'b1;
        @(negedge sys_clk_in);
        block_lost_in = 1'b0;
        start(1'b1);
        put_hdr(8'h02, 16'h0001, 1'b1);
        put_data(2, 8'h80);
        pad_to(4, 512, 8'hFF);
        put_hdr(8'h01, 16'h0002, 1'b1);
        put_data(3, 8'h90);
        pad_to(516, 4, 8'h00);
        frame_len();
        run(2'h1, 1'b0, 7'h01, 8'h03, 1'b1);
        $display("multi done");
    endtask : t_multi

    task automatic t_status();
        logic [7:0] v;
        start(1'b0);
        put_data(4, 8'hC0);
        run(2'h3, 1'b1, 7'h00, 8'h04, 1'b0);
        check(irq_out, 1'b1);
        reg_rd(8'h2D, v);
        check(v, 8'h20);
        repeat (2) @(negedge sys_clk_in);
        check(irq_out, 1'b0);
        reg_wr(8'h07, 8'h04);
        start(1'b1);
        put_hdr(8'h01, 16'h0003, 1'b1);
        put_data(1, 8'hD0);
        pad_to(4, 4, 8'h00);
        frame_len();
        fork
            run(2'h3, 1'b0, 7'h00, 8'h01, 1'b0);
            begin
                repeat (10) @(negedge sys_clk_in);
                check(req_ready_out, 1'b1);
                reg_wr(8'h06, 8'h01); // switch to async mode
            end
        join
        check(irq_out, 1'b1);
        reg_rd(8'h2D, v);
        check(v, 8'h40);
        $display("status done");
    endtask : t_status

    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_total++;
        stop_test();
    end

    // reset, then the scenarios in turn
    initial begin
        {rst_n_in, req_valid_in, req_resp_in, req_chan_in} = '0;
        {req_nfull_in, req_last_len_in, in_data_in, in_valid_in} = '0;
        {in_last_in, block_lost_in, slow_in, reg_wr_in, reg_rd_in} = '0;
        {reg_addr_in, reg_wdata_in} = '0;
        ce_in = 1'b1;
        stamp_in = 40'h0A_1B2C_3D4E;
        repeat (5) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        @(negedge sys_clk_in);
        t_regs();
        t_single();
        t_multi();
        t_status();
        stop_test();
    end
endmodule : sfof_framer_test

`default_nettype wire

// ===== verification/sfof_host_model.sv
// host side model that drains the framer output stream
`default_nettype none

module sfof_host_model (
    // clock
    input wire logic sys_clk_in,
    // stream from the framer
    input wire logic [7:0] data_in,
    input wire logic valid_in,
    // pacing choice from the bench
    input wire logic slow_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got_q[$];
    int tick = 0;

    initial ready_out = 1'b0;

    // slow mode stalls two cycles of three; logs each handshaken byte
    always @(negedge sys_clk_in) begin
        tick = tick + 1;
        ready_out = !slow_in || (tick % 3 == 0);
        // filler is logged raw; a parser would step over it here
        if (valid_in && ready_out)
            got_q.push_back(data_in); // arrival order kept
    end
endmodule : sfof_host_model

`default_nettype wire
